// File: rtl/tiopc_pkg.sv
package tiopc_pkg;
   localparam int NPORT = 5;
   localparam int NCB = 6;
   localparam int NPIN = 32;
   localparam int CTRW = 16;
   localparam int DIVW = 8;
   localparam logic [NCB-1:0] TICK_RST = 6'h01;
   localparam logic [31:0] PULL_RST = 32'hFFFFFFFF;
   localparam logic [1:0] COND_NONE = 2'h0;
   localparam logic [1:0] COND_EQ = 2'h1;
   localparam logic [1:0] COND_NE = 2'h2;
   localparam logic [1:0] BUF_FULL = 2'h2;

   // ports nest on the low pins, so a lower index is always the narrower port
   function automatic int portWidth(input int k);
      case (k)
         0: return 1;
         1: return 4;
         2: return 8;
         3: return 16;
         default: return 32;
      endcase
   endfunction : portWidth

   function automatic logic [NPIN-1:0] portMask(input int k);
      return NPIN'((64'h1 << portWidth(k)) - 64'h1);
   endfunction : portMask

   function automatic logic [5:0] lastSlice(input int k);
      return 6'(NPIN / portWidth(k) - 1);
   endfunction : lastSlice

   // an out-of-range selection falls back to the reference block
   function automatic int cbIndex(input logic [2:0] sel);
      return (int'(sel) < NCB) ? int'(sel) : 0;
   endfunction : cbIndex

   typedef struct packed {
      logic en;
      logic dirOut;
      logic openColl;
      logic strobeEn;
      logic [2:0] clkSel;
      logic [1:0] condMode;
      logic [NPIN-1:0] condVal;
      logic timed;
      logic [CTRW-1:0] timeVal;
   } tiopc_cfg_t;

   typedef struct packed {
      logic fromPin;
      logic [DIVW-1:0] div;
   } tiopc_cb_t;

   typedef struct packed {
      logic [NPIN-1:0] data;
      logic [CTRW-1:0] ts;
   } tiopc_word_t;

   typedef struct packed {
      tiopc_word_t [1:0] ent;
      logic [1:0] cnt;
   } tiopc_buf_t;

   typedef struct packed {
      tiopc_cfg_t cfg;
      tiopc_buf_t fifo;
      logic [NPIN-1:0] sh;
      logic [5:0] slice;
      logic busy;
      logic [CTRW-1:0] ctr;
      logic [CTRW-1:0] ts;
   } tiopc_port_t;

   typedef struct packed {
      tiopc_port_t [NPORT-1:0] p;
      tiopc_cb_t [NCB-1:0] cb;
      logic [NCB-1:0][DIVW-1:0] cbCnt;
      logic [NCB-1:0] tick;
      logic clkPinPrev;
      logic link;
      logic [NPIN-1:0] pinOut;
      logic [NPIN-1:0] pinOe;
      logic [NPIN-1:0] pull;
      logic [NPORT-1:0] strobe;
      logic [NPORT-1:0] evt;
      logic [NPORT-1:0] wrRdy;
      logic [NPORT-1:0] rdVld;
   } tiopc_state_t;
endpackage : tiopc_pkg

// File: rtl/tiopc_top.sv
`timescale 1ns/1ps
// How it works
// - ports of 1, 4, 8, 16 and 32 bits sit on fixed pin groups
// - each port is wholly input or wholly output
// - ports drive or sample pins; input ports can wait for a pin condition, output ports start without one
// - a processor access completes in one cycle unless the buffer is full (write) or empty (read)
// - open collector drives low for zero, floats for one
// - open collector is chosen per port for all its pins
// - data passes through a shift register and a transfer buffer
// - a 16-bit counter per port times transfers
// - counter is always readable; transfers can wait for a counter value
// - each transfer stamps the counter value for software
// - an enabled link stops ports driving its pins; input ports still sample them
// - an enabled narrower port overrides wider ports on shared pins
// - unshared pins of a wider port stay usable
// - ports always transfer at their own width
// - block 0 is the reference clock
// - blocks 1 to 5 run at programmable rates
// - the selected clock block paces each port
// - a clock block may take its clock from the 1-bit port pin
// - a pin-sourced clock may be divided
// - input ports qualify samples with an external strobe
// - output ports produce a strobe with their data
// - after reset every port uses clock block 0
// - pin condition matches are signalled directly as events
// - pulls are on after reset and drop when a port or link enables
module tiopc_top
   import tiopc_pkg::*;
#(
   parameter logic [NPIN-1:0] LINK_MASK = 32'h0000F000
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // configuration
   input wire logic [NPORT-1:0] cfgLoad,
   input wire tiopc_cfg_t [NPORT-1:0] cfgIn,
   input wire logic [NCB-1:0] cbLoad,
   input wire tiopc_cb_t [NCB-1:0] cbIn,
   input wire logic linkEn,
   input wire logic pullWr,
   input wire logic [NPIN-1:0] pullVal,
   // processor data
   input wire logic [NPORT-1:0] wrValid,
   input wire logic [NPORT-1:0][NPIN-1:0] wrData,
   output logic [NPORT-1:0] wrReady,
   input wire logic [NPORT-1:0] rdReady,
   output logic [NPORT-1:0] rdValid,
   output logic [NPORT-1:0][NPIN-1:0] rdData,
   output logic [NPORT-1:0][CTRW-1:0] rdTime,
   // status
   output logic [NPORT-1:0][CTRW-1:0] ctrOut,
   output logic [NPORT-1:0][CTRW-1:0] lastTs,
   output logic [NPORT-1:0] pinEvent,
   output logic [NPIN-1:0] pullEn,
   // pins
   input wire logic [NPIN-1:0] pinIn,
   output logic [NPIN-1:0] pinOut,
   output logic [NPIN-1:0] pinOe,
   input wire logic [NPORT-1:0] strobeIn,
   output logic [NPORT-1:0] strobe_out
);
   // pin 0 doubles as the clock source; a link there would starve the blocks
   if (LINK_MASK[0]) begin : g_bad_mask
      $error("link mask must leave pin 0 free");
   end

   tiopc_state_t st;
   tiopc_state_t n;

   // two-entry buffer; callers never push into a full buffer without a pop
   function automatic tiopc_buf_t fifoStep(input tiopc_buf_t f, input logic push,
                                          input tiopc_word_t w, input logic pop);
      tiopc_buf_t r;
      r = f;
      if (pop && f.cnt != 2'h0) begin
         r.ent[0] = f.ent[1];
         r.cnt = f.cnt - 2'h1;
      end
      if (push) begin
         r.ent[r.cnt[0]] = w;
         r.cnt = r.cnt + 2'h1;
      end
      return r;
   endfunction : fifoStep

   always_comb begin
      logic [NPIN-1:0] pv;
      logic tk;
      logic srcEv;
      logic condOk;
      logic timeOk;
      logic done;
      logic start;
      logic push;
      logic pop;
      logic smp;
      logic val;
      tiopc_word_t w;
      int own;
      n = st;
      pv = '0;
      tk = 1'b0;
      srcEv = 1'b0;
      condOk = 1'b0;
      timeOk = 1'b0;
      done = 1'b0;
      start = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      smp = 1'b0;
      val = 1'b0;
      w = '0;
      own = -1;
      n.clkPinPrev = pinIn[0];
      n.link = linkEn;
      n.tick[0] = 1'b1;
      for (int b = 1; b < NCB; b++) begin
         srcEv = st.cb[b].fromPin ? (pinIn[0] & ~st.clkPinPrev) : 1'b1;
         n.tick[b] = 1'b0;
         if (cbLoad[b]) begin
            n.cb[b] = cbIn[b];
            n.cbCnt[b] = '0;
         end else if (srcEv) begin
            if (st.cbCnt[b] == st.cb[b].div) begin
               n.tick[b] = 1'b1;
               n.cbCnt[b] = '0;
            end else begin
               n.cbCnt[b] = st.cbCnt[b] + 8'h01;
            end
         end
      end
      if (pullWr) begin
         n.pull = pullVal;
      end
      if (linkEn && !st.link) begin
         n.pull = n.pull & ~LINK_MASK;
      end
      for (int k = 0; k < NPORT; k++) begin
         pv = pinIn & portMask(k);
         tk = st.p[k].cfg.en & st.tick[cbIndex(st.p[k].cfg.clkSel)];
         unique case (st.p[k].cfg.condMode)
            COND_EQ: condOk = (pv == (st.p[k].cfg.condVal & portMask(k)));
            COND_NE: condOk = (pv != (st.p[k].cfg.condVal & portMask(k)));
            default: condOk = 1'b1;
         endcase
         timeOk = !st.p[k].cfg.timed || (st.p[k].ctr == st.p[k].cfg.timeVal);
         done = st.p[k].busy && (st.p[k].slice == lastSlice(k));
         start = 1'b0;
         push = 1'b0;
         pop = 1'b0;
         smp = 1'b0;
         w = '0;
         n.evt[k] = tk && (st.p[k].cfg.condMode != COND_NONE) && condOk;
         if (tk) begin
            n.p[k].ctr = st.p[k].ctr + 16'h0001;
         end
         if (st.p[k].cfg.dirOut) begin
            push = wrValid[k] && st.wrRdy[k];
            w.data = wrData[k];
            start = tk && (!st.p[k].busy || done) && (st.p[k].fifo.cnt != 2'h0) && timeOk;
            pop = start;
            if (start) begin
               n.p[k].sh = st.p[k].fifo.ent[0].data;
               n.p[k].slice = '0;
               n.p[k].busy = 1'b1;
               n.p[k].ts = st.p[k].ctr;
            end else if (tk && done) begin
               n.p[k].busy = 1'b0;
            end else if (tk && st.p[k].busy) begin
               n.p[k].sh = st.p[k].sh >> portWidth(k);
               n.p[k].slice = st.p[k].slice + 6'h01;
            end
         end else begin
            smp = tk && (!st.p[k].cfg.strobeEn || strobeIn[k]) && condOk
                  && (st.p[k].slice != 6'h00 || timeOk)
                  && !(st.p[k].slice == lastSlice(k) && st.p[k].fifo.cnt == BUF_FULL);
            pop = rdReady[k] && st.rdVld[k];
            if (smp) begin
               n.p[k].sh = (st.p[k].sh >> portWidth(k)) | (pv << (NPIN - portWidth(k)));
               if (st.p[k].slice == lastSlice(k)) begin
                  push = 1'b1;
                  w.data = n.p[k].sh;
                  w.ts = st.p[k].ctr;
                  n.p[k].ts = st.p[k].ctr;
                  n.p[k].slice = '0;
               end else begin
                  n.p[k].slice = st.p[k].slice + 6'h01;
               end
            end
         end
         n.p[k].fifo = fifoStep(st.p[k].fifo, push, w, pop);
         if (cfgLoad[k]) begin
            if (cfgIn[k].en && !st.p[k].cfg.en) begin
               n.pull = n.pull & ~portMask(k);
            end
            // disabling or turning a port round discards words of the old direction
            if (!cfgIn[k].en || cfgIn[k].dirOut != st.p[k].cfg.dirOut) begin
               n.p[k].fifo.cnt = 2'h0;
            end
            n.p[k].cfg = cfgIn[k];
            n.p[k].busy = 1'b0;
            n.p[k].slice = '0;
         end
         n.wrRdy[k] = n.p[k].cfg.en && n.p[k].cfg.dirOut && (n.p[k].fifo.cnt != BUF_FULL);
         n.rdVld[k] = n.p[k].cfg.en && !n.p[k].cfg.dirOut && (n.p[k].fifo.cnt != 2'h0);
         n.strobe[k] = n.p[k].cfg.dirOut && n.p[k].cfg.strobeEn && n.p[k].busy;
      end
      for (int i = 0; i < NPIN; i++) begin
         own = -1;
         for (int k = NPORT - 1; k >= 0; k--) begin
            if (n.p[k].cfg.en && i < portWidth(k)) begin
               own = k;
            end
         end
         n.pinOut[i] = 1'b0;
         n.pinOe[i] = 1'b0;
         if (own >= 0 && !(n.link && LINK_MASK[i])) begin
            if (n.p[own].cfg.dirOut) begin
               val = n.p[own].sh[i];
               if (n.p[own].cfg.openColl) begin
                  n.pinOe[i] = ~val;
               end else begin
                  n.pinOut[i] = val;
                  n.pinOe[i] = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st <= '0;
         st.tick <= TICK_RST;
         st.pull <= PULL_RST;
      end else begin
         st <= n;
      end
   end

   for (genvar k = 0; k < NPORT; k++) begin : g_out
      assign rdData[k] = st.p[k].fifo.ent[0].data;
      assign rdTime[k] = st.p[k].fifo.ent[0].ts;
      assign ctrOut[k] = st.p[k].ctr;
      assign lastTs[k] = st.p[k].ts;
   end
   assign wrReady = st.wrRdy;
   assign rdValid = st.rdVld;
   assign pinEvent = st.evt;
   assign pullEn = st.pull;
   assign pinOut = st.pinOut;
   assign pinOe = st.pinOe;
   assign strobe_out = st.strobe;

   for (genvar k = 0; k < NPORT; k++) begin : g_chk
      a_ts_stamp: assert property (
         @(posedge clk) disable iff (reset)
         $changed(st.p[k].ts) |-> st.p[k].ts == $past(st.p[k].ctr))
         else $error("timestamp is not the counter value");
      a_ctr_step: assert property (
         @(posedge clk) disable iff (reset)
         (st.p[k].cfg.en && st.tick[cbIndex(st.p[k].cfg.clkSel)])
         |=> st.p[k].ctr == $past(st.p[k].ctr) + 16'h0001)
         else $error("counter missed a tick");
      a_clk_default: assert property (
         @(posedge clk) disable iff (reset)
         $changed(st.p[k].cfg.clkSel) |-> $past(cfgLoad[k]))
         else $error("clock selection moved without a load");
      a_full_stall: assert property (
         @(posedge clk) disable iff (reset)
         st.p[k].fifo.cnt == BUF_FULL |-> !wrReady[k] ##1 st.p[k].fifo.cnt != 2'h3)
         else $error("full buffer still accepts");
      a_pull_drop: assert property (
         @(posedge clk) disable iff (reset)
         $rose(st.p[k].cfg.en) |-> (pullEn & portMask(k)) == '0)
         else $error("pull still on after port enable");
      a_event_cond: assert property (
         @(posedge clk) disable iff (reset)
         st.evt[k] |-> $past(st.p[k].cfg.condMode) != COND_NONE)
         else $error("event without a pin condition");
      a_ctr_hold: assert property (
         @(posedge clk) disable iff (reset)
         !(st.p[k].cfg.en && st.tick[cbIndex(st.p[k].cfg.clkSel)])
         |=> st.p[k].ctr == $past(st.p[k].ctr))
         else $error("counter moved without a tick");
      a_accept_one: assert property (
         @(posedge clk) disable iff (reset)
         wrValid[k] && wrReady[k] && !cfgLoad[k] |=> st.p[k].fifo.cnt != 2'h0)
         else $error("accepted word not buffered");
      a_strobe_idle: assert property (
         @(posedge clk) disable iff (reset)
         !st.p[k].busy |-> !strobe_out[k])
         else $error("strobe without output data");
      a_stamp_in: assert property (
         @(posedge clk) disable iff (reset)
         $rose(st.rdVld[k]) |-> rdTime[k] == st.p[k].ts)
         else $error("buffered stamp differs from last stamp");
   end

   a_tick_ref: assert property (
      @(posedge clk) disable iff (reset) st.tick[0])
      else $error("reference block missed a tick");

   sequence s_div_one;
      st.tick[1] && st.cb[1].div == 8'h01 && !st.cb[1].fromPin ##0 !cbLoad[1] ##1 !cbLoad[1];
   endsequence
   a_div_space: assert property (
      @(posedge clk) disable iff (reset) s_div_one |-> !st.tick[1] ##1 st.tick[1])
      else $error("divide by two spacing wrong");

   a_oc_drive: assert property (
      @(posedge clk) disable iff (reset)
      (st.p[1].cfg.en && st.p[1].cfg.dirOut && st.p[1].cfg.openColl
       && !(st.link && LINK_MASK[1]))
      |-> !pinOut[1] && pinOe[1] == !st.p[1].sh[1])
      else $error("open collector drive wrong");

   a_link_off: assert property (
      @(posedge clk) disable iff (reset) st.link |-> (pinOe & LINK_MASK) == '0)
      else $error("link pins still driven");

   a_narrow_wins: assert property (
      @(posedge clk) disable iff (reset)
      (st.p[0].cfg.en && st.p[0].cfg.dirOut && !st.p[0].cfg.openColl && st.p[1].cfg.en)
      |-> pinOe[0] && pinOut[0] == st.p[0].sh[0])
      else $error("pin ownership wrong");

   // pins 0 to 7 belong to the byte port while both narrower ports are off
   a_in_quiet: assert property (
      @(posedge clk) disable iff (reset)
      (st.p[2].cfg.en && !st.p[2].cfg.dirOut && !st.p[1].cfg.en && !st.p[0].cfg.en)
      |-> (pinOe & portMask(2)) == '0)
      else $error("input port drives its pins");

   a_link_pull: assert property (
      @(posedge clk) disable iff (reset) $rose(st.link) |-> (pullEn & LINK_MASK) == '0)
      else $error("pull still on under the link");

   // only the widest port reaches the upper half of the pins
   a_upper_pins: assert property (
      @(posedge clk) disable iff (reset) !st.p[4].cfg.en |-> pinOe[31:16] == '0)
      else $error("upper pins driven without the wide port");

   a_timed_start: assert property (
      @(posedge clk) disable iff (reset)
      $rose(st.p[3].busy) && st.p[3].cfg.timed |-> $past(st.p[3].ctr) == st.p[3].cfg.timeVal)
      else $error("timed output started early");

   sequence s_load1;
      $rose(st.p[1].busy) ##0 st.p[1].cfg.strobeEn;
   endsequence
   a_strobe_load: assert property (
      @(posedge clk) disable iff (reset) s_load1 |-> strobe_out[1])
      else $error("strobe missing with output data");
endmodule : tiopc_top

// File: verif/tiopc_pins.sv
`timescale 1ns/1ps
module tiopc_pins
   import tiopc_pkg::*;
(
   // device side
   input wire logic clk,
   input wire logic [NPIN-1:0] pinOut,
   input wire logic [NPIN-1:0] pinOe,
   input wire logic [NPIN-1:0] pullEn,
   output logic [NPIN-1:0] pinIn,
   // external source
   input wire logic [NPIN-1:0] extVal,
   input wire logic [NPIN-1:0] extEn
);
   // toggles so a floating pin never looks like a steady value
   logic [NPIN-1:0] flip = '0;

   always_ff @(posedge clk) begin
      flip <= ~flip;
   end

   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         if (pinOe[i]) pinIn[i] = pinOut[i];
         else if (extEn[i]) pinIn[i] = extVal[i];
         else if (pullEn[i]) pinIn[i] = 1'b0;
         else pinIn[i] = flip[i];
      end
   end
endmodule : tiopc_pins

// File: verif/timed_io_port_clocking_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
   checks++; \
   if ((got) !== (ex)) begin \
      mismatches++; \
      $display("unexpected %s: expected %0h, seen %0h", nm, ex, got); \
   end \
end
`define WAITON(c) begin \
   int w = 0; \
   while ((c) !== 1'b1 && w < 300) begin \
      tick(1); \
      w++; \
   end \
   if ((c) !== 1'b1) begin \
      mismatches++; \
      give_verdict(); \
   end \
end
module timed_io_port_clocking_test;
   import tiopc_pkg::*;
   logic clk, reset, linkEn, pullWr;
   logic [NPORT-1:0] cfgLoad, wrValid, wrReady, rdReady, rdValid, pinEvent;
   logic [NPORT-1:0] strobeIn, strobe_out;
   tiopc_cfg_t [NPORT-1:0] cfgIn;
   logic [NCB-1:0] cbLoad;
   tiopc_cb_t [NCB-1:0] cbIn;
   logic [NPIN-1:0] pullVal, pullEn, pinIn, pinOut, pinOe, extVal, extEn;
   logic [NPORT-1:0][NPIN-1:0] wrData, rdData;
   logic [NPORT-1:0][CTRW-1:0] rdTime, ctrOut, lastTs;
   int checks = 0;
   int mismatches = 0;

   tiopc_top DUT (.clk, .reset, .cfgLoad, .cfgIn, .cbLoad, .cbIn, .linkEn, .pullWr,
      .pullVal, .wrValid, .wrData, .wrReady, .rdReady, .rdValid, .rdData, .rdTime,
      .ctrOut, .lastTs, .pinEvent, .pullEn, .pinIn, .pinOut, .pinOe, .strobeIn,
      .strobe_out);
   tiopc_pins PAR (.clk, .pinOut, .pinOe, .pullEn, .pinIn, .extVal, .extEn);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   function automatic tiopc_cfg_t mk(logic o, logic oc, logic st, logic [2:0] cs,
         logic [1:0] cm, logic [31:0] cv, logic tm, logic [15:0] tv);
      return '{1'b1, o, oc, st, cs, cm, cv, tm, tv};
   endfunction : mk

   task automatic cfg(input int k, input tiopc_cfg_t c);
      cfgIn[k] = c;
      cfgLoad[k] = 1'b1;
      tick(1);
      cfgLoad[k] = 1'b0;
      tick(1);
   endtask : cfg

   task automatic put(input int k, input logic [31:0] w);
      wrData[k] = w;
      wrValid[k] = 1'b1;
      tick(1);
      wrValid[k] = 1'b0;
      tick(1);
   endtask : put

   task automatic serial_out();
      logic [31:0] w = 32'hC3A50F96;
      cfg(0, mk(1'b1, 1'b0, 1'b1, 3'h0, COND_NONE, 32'h0, 1'b0, 16'h0));
      `CHK("ready", 1'b1, wrReady[0])
      `CHK("pull", 1'b0, pullEn[0])
      put(0, w);
      `WAITON(strobe_out[0])
      for (int i = 0; i < 32; i++) begin
         `CHK("pin0", w[i], pinOut[0])
         `CHK("strobe", 1'b1, strobe_out[0])
         tick(1);
      end
   endtask : serial_out

   task automatic open_coll();
      logic [31:0] w = 32'h00000009;
      cfg(1, mk(1'b1, 1'b1, 1'b1, 3'h0, COND_NONE, 32'h0, 1'b0, 16'h0));
      put(1, w);
      `WAITON(strobe_out[1])
      `CHK("ocOe", ~w[3:1], pinOe[3:1])
      `CHK("ocOut", 3'h0, pinOut[3:1])
      `CHK("narrowOe", 1'b1, pinOe[0])
      `CHK("narrowOut", 1'b1, pinOut[0])
      cfg(0, '0);
      cfg(1, '0);
   endtask : open_coll

   task automatic timed_out();
      logic [15:0] c0, tv;
      cfg(3, mk(1'b1, 1'b0, 1'b0, 3'h0, COND_NONE, 32'h0, 1'b0, 16'h0));
      c0 = ctrOut[3];
      tick(1);
      `CHK("ctrStep", 16'(c0 + 16'h1), ctrOut[3])
      tv = 16'(c0 + 16'h40);
      cfg(3, mk(1'b1, 1'b0, 1'b0, 3'h0, COND_NONE, 32'h0, 1'b1, tv));
      put(3, 32'h1234ABCD);
      put(3, 32'h55AA6699);
      `CHK("full", 1'b0, wrReady[3])
      `WAITON(wrReady[3])
      `CHK("stamp", tv, lastTs[3])
      `CHK("slice0", 16'hABCD, pinOut[15:0])
      tick(1);
      `CHK("freed", 1'b1, wrReady[3])
      cfg(3, '0);
   endtask : timed_out

   task automatic strobed_in();
      logic [31:0] w [2] = '{32'h8E7D6C5B, 32'h01F2E3D4};
      logic [15:0] ts [2];
      cfg(2, mk(1'b0, 1'b0, 1'b1, 3'h0, COND_NONE, 32'h0, 1'b0, 16'h0));
      extEn[7:0] = 8'hFF;
      for (int n = 0; n < 2; n++) begin
         for (int s = 0; s < 4; s++) begin
            extVal[7:0] = w[n][8*s +: 8];
            strobeIn[2] = 1'b1;
            if (s == 3) begin
               ts[n] = ctrOut[2];
            end
            tick(1);
            extVal[7:0] = ~w[n][8*s +: 8];
            strobeIn[2] = 1'b0;
            tick(1);
         end
      end
      `CHK("noDrive", 8'h00, pinOe[7:0])
      for (int n = 0; n < 2; n++) begin
         `WAITON(rdValid[2])
         `CHK("rdWord", w[n], rdData[2])
         `CHK("rdTime", ts[n], rdTime[2])
         rdReady[2] = 1'b1;
         tick(1);
      end
      rdReady[2] = 1'b0;
      `CHK("drained", 1'b0, rdValid[2])
      cfg(2, '0);
   endtask : strobed_in

   task automatic cond_event();
      cfg(1, mk(1'b0, 1'b0, 1'b0, 3'h0, COND_EQ, 32'h5, 1'b0, 16'h0));
      extVal[3:0] = 4'h5;
      extEn[3:0] = 4'hF;
      `WAITON(pinEvent[1])
      `CHK("event", 1'b1, pinEvent[1])
      extVal[3:0] = 4'h6;
      tick(3);
      for (int i = 0; i < 5; i++) begin
         `CHK("noEvent", 1'b0, pinEvent[1])
         tick(1);
      end
      cfg(1, mk(1'b0, 1'b0, 1'b0, 3'h0, COND_NE, 32'h5, 1'b0, 16'h0));
      `CHK("neEvent", 1'b1, pinEvent[1])
      cfg(1, '0);
   endtask : cond_event

   task automatic pin_clock();
      logic [15:0] c0;
      cbIn[1] = '{1'b1, 8'h01};
      cbLoad[1] = 1'b1;
      tick(1);
      cbLoad[1] = 1'b0;
      extVal[0] = 1'b0;
      cfg(3, mk(1'b0, 1'b0, 1'b0, 3'h1, COND_NONE, 32'h0, 1'b0, 16'h0));
      c0 = ctrOut[3];
      for (int i = 0; i < 6; i++) begin
         extVal[0] = 1'b1;
         tick(2);
         extVal[0] = 1'b0;
         tick(2);
      end
      tick(3);
      `CHK("pinClk", 16'(c0 + 16'h3), ctrOut[3])
      cbIn[1] = '{1'b0, 8'h01};
      cbLoad[1] = 1'b1;
      tick(1);
      cbLoad[1] = 1'b0;
      c0 = ctrOut[3];
      tick(8);
      `CHK("divClk", 16'(c0 + 16'h3), ctrOut[3])
   endtask : pin_clock

   task automatic link_pins();
      extEn = '0;
      cfg(3, mk(1'b1, 1'b0, 1'b0, 3'h0, COND_NONE, 32'h0, 1'b0, 16'h0));
      pullVal = '1;
      pullWr = 1'b1;
      tick(1);
      pullWr = 1'b0;
      linkEn = 1'b1;
      tick(2);
      `CHK("linkOe", 4'h0, pinOe[15:12])
      `CHK("portOe", 12'hFFF, pinOe[11:0])
      `CHK("linkPull", 4'h0, pullEn[15:12])
   endtask : link_pins

   initial begin
      reset = 1'b1;
      cfgLoad = '0;
      cfgIn = '0;
      cbLoad = '0;
      cbIn = '0;
      linkEn = 1'b0;
      pullWr = 1'b0;
      pullVal = '0;
      wrValid = '0;
      wrData = '0;
      rdReady = '0;
      strobeIn = '0;
      extVal = '0;
      extEn = '0;
      tick(2);
      reset = 1'b0;
      `CHK("pullRst", PULL_RST, pullEn)
      `CHK("oeRst", 32'h0, pinOe)
      serial_out();
      open_coll();
      timed_out();
      strobed_in();
      cond_event();
      pin_clock();
      link_pins();
      give_verdict();
   end

   // cuts a hang short well inside the run budget
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
endmodule : timed_io_port_clocking_test
